// ### verilog/cpmc_pkg.sv
// Package: modes, clock modes, timing constants for the power mode controller
package cpmc_pkg;

  typedef enum logic [2:0] {
    CPMC_RUN,
    CPMC_WAIT,
    CPMC_STOP,
    CPMC_VLP_RUN,
    CPMC_VLP_WAIT,
    CPMC_VLP_STOP,
    CPMC_LL_STOP
  } cpmc_mode_t;

  // Core sleep state encoding
  localparam logic [1:0] CORE_RUN = 2'h0;
  localparam logic [1:0] CORE_SLEEP = 2'h1;
  localparam logic [1:0] CORE_DEEP = 2'h2;

  // Clock generator mode encoding
  localparam logic [1:0] CLKM_NORMAL = 2'h0;
  localparam logic [1:0] CLKM_BYPASSED_LOWPOWER_INTERNAL_CLK = 2'h1;
  localparam logic [1:0] CLKM_BYPASSED_LOWPOWER_EXTERNAL_CLK = 2'h2;

  // External clock source select in bypassed external mode
  localparam logic SRC_EXT_CLK = 1'b0;
  localparam logic SRC_CRYSTAL = 1'b1;

  // Always-on peripheral gate positions
  localparam int PG_OSC = 0;
  localparam int PG_LOW_POWER_TIMER = 1;
  localparam int PG_RTC = 2;
  localparam int PG_CMP = 3;
  localparam int PG_TSI = 4;
  localparam int PG_TPM = 5;
  localparam int PG_UART = 6;
  localparam int PG_WAKEUP = 7;
  localparam int PG_WIDTH = 8;
  localparam logic [PG_WIDTH-1:0] PG_ALL_ON = 8'hff;

  // Clock figures
  localparam int CLK_RATE_KHZ = 125000;
  localparam int FLASH_LP_KHZ = 1000;
  localparam int BUS_LP_MAX_KHZ = 800;
  localparam int FIRC_NOM_KHZ = 4000;
  // Flash divider is rounded down, bus divider rounded up; never below one cycle
  localparam int FLASH_LP_DIV = CLK_RATE_KHZ / FLASH_LP_KHZ;
  localparam int BUS_LP_DIV = (CLK_RATE_KHZ + BUS_LP_MAX_KHZ - 1) / BUS_LP_MAX_KHZ;

endpackage : cpmc_pkg

// ### verilog/cpmc_core_if.sv
// Interface: core sleep request bundle from the top ports and pin synchroniser to the mode engine
`timescale 1ns/10ps
interface cpmc_core_if;
  logic wfi_req;
  logic deep_sel;
  logic wake;
  logic low_leakage_wakeup_unit_wake;
  modport src (output wfi_req, output deep_sel, output wake, output low_leakage_wakeup_unit_wake);
  modport dst (input wfi_req, input deep_sel, input wake, input low_leakage_wakeup_unit_wake);
endinterface : cpmc_core_if

// ### verilog/cpmc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module cpmc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  initial begin
    if (W < 1) $error("cpmc_sync: W must be at least 1");
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : cpmc_sync

// ### verilog/cpmc_top.sv
// Chip power mode controller top
`timescale 1ns/10ps
module cpmc_top
  import cpmc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Core requests
  input wire logic wfi_req_i,
  input wire logic deep_sel_i,
  input wire logic vlp_req_i,
  input wire logic ll_stop_sel_i,
  // Wake sources (pins, asynchronous)
  input wire logic irq_pend_i,
  input wire logic low_leakage_wakeup_unit_wake_i,
  // Clock sources
  input wire logic [1:0] clk_mode_i,
  input wire logic ext_src_sel_i,
  input wire logic tpm_src_on_i,
  input wire logic uart_src_on_i,
  // Mode status
  output cpmc_pkg::cpmc_mode_t mode_o,
  output logic [1:0] core_state_o,
  // Control outputs
  output logic nested_irq_controller_en_o,
  output logic async_wake_irq_controller_en_o,
  output logic low_leakage_wakeup_unit_en_o,
  output logic periph_clk_en_o,
  output logic [PG_WIDTH-1:0] aon_clk_en_o,
  output logic reg_lowpower_o,
  output logic flash_lp_o,
  output logic flash_lp_clk_o,
  output logic bus_lp_clk_o,
  output logic low_voltage_detect_en_o,
  output logic fast_core_clock_en_o,
  output logic sram_retain_o,
  output logic io_hold_o,
  output logic periph_retain_o,
  output logic use_internal_ref_o,
  output logic use_crystal_o,
  output logic clk_mode_err_o
);
  import cpmc_pkg::*;

  // ----------------------------------------------------------------
  // Wake inputs
  // ----------------------------------------------------------------
  logic [1:0] wake_s;
  cpmc_core_if cif ();

  cpmc_sync #(.W(2)) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i({low_leakage_wakeup_unit_wake_i, irq_pend_i}),
    .sync_o(wake_s)
  );

  assign cif.wfi_req = wfi_req_i;
  assign cif.deep_sel = deep_sel_i;
  assign cif.wake = wake_s[0];
  assign cif.low_leakage_wakeup_unit_wake = wake_s[1];

  // ----------------------------------------------------------------
  // Mode engine
  // ----------------------------------------------------------------
  cpmc_mode_t mode_r;
  cpmc_mode_t mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      CPMC_RUN: begin
        if (cif.wfi_req) begin
          if (!cif.deep_sel) begin
            mode_nxt = CPMC_WAIT;
          end else if (ll_stop_sel_i) begin
            mode_nxt = CPMC_LL_STOP;
          end else begin
            mode_nxt = CPMC_STOP;
          end
        end else if (vlp_req_i) begin
          mode_nxt = CPMC_VLP_RUN;
        end
      end
      CPMC_WAIT: begin
        if (cif.wake) begin
          mode_nxt = CPMC_RUN;
        end
      end
      CPMC_STOP: begin
        if (cif.wake) begin
          mode_nxt = CPMC_RUN;
        end
      end
      CPMC_VLP_RUN: begin
        if (cif.wfi_req) begin
          if (!cif.deep_sel) begin
            mode_nxt = CPMC_VLP_WAIT;
          end else if (ll_stop_sel_i) begin
            mode_nxt = CPMC_LL_STOP;
          end else begin
            mode_nxt = CPMC_VLP_STOP;
          end
        end else if (!vlp_req_i) begin
          mode_nxt = CPMC_RUN;
        end
      end
      CPMC_VLP_WAIT: begin
        if (cif.wake) begin
          mode_nxt = CPMC_VLP_RUN;
        end
      end
      CPMC_VLP_STOP: begin
        if (cif.wake) begin
          mode_nxt = CPMC_VLP_RUN;
        end
      end
      CPMC_LL_STOP: begin
        // Only the wake-up unit can bring the chip back; normal run resumes
        if (cif.low_leakage_wakeup_unit_wake) begin
          mode_nxt = CPMC_RUN;
        end
      end
      default: begin
        mode_nxt = CPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r <= CPMC_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Mode controls, registered from the next mode
  // ----------------------------------------------------------------
  logic vlp_family;
  logic [PG_WIDTH-1:0] aon_nxt;
  assign vlp_family = (mode_nxt == CPMC_VLP_RUN) || (mode_nxt == CPMC_VLP_WAIT)
                   || (mode_nxt == CPMC_VLP_STOP);

  always_comb begin
    aon_nxt = PG_ALL_ON;
    if (mode_nxt == CPMC_VLP_STOP) begin
      aon_nxt = '0;
      aon_nxt[PG_OSC] = 1'b1;
      aon_nxt[PG_LOW_POWER_TIMER] = 1'b1;
      aon_nxt[PG_RTC] = 1'b1;
      aon_nxt[PG_CMP] = 1'b1;
      aon_nxt[PG_TSI] = 1'b1;
      aon_nxt[PG_TPM] = tpm_src_on_i;
      aon_nxt[PG_UART] = uart_src_on_i;
    end else if (mode_nxt == CPMC_LL_STOP) begin
      aon_nxt = '0;
      aon_nxt[PG_OSC] = 1'b1;
      aon_nxt[PG_WAKEUP] = 1'b1;
      aon_nxt[PG_LOW_POWER_TIMER] = 1'b1;
      aon_nxt[PG_RTC] = 1'b1;
      aon_nxt[PG_CMP] = 1'b1;
      aon_nxt[PG_TSI] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_state_o <= CORE_RUN;
      nested_irq_controller_en_o <= 1'b1;
      async_wake_irq_controller_en_o <= 1'b0;
      low_leakage_wakeup_unit_en_o <= 1'b0;
      periph_clk_en_o <= 1'b1;
      aon_clk_en_o <= PG_ALL_ON;
      reg_lowpower_o <= 1'b0;
      flash_lp_o <= 1'b0;
      low_voltage_detect_en_o <= 1'b1;
      fast_core_clock_en_o <= 1'b1;
      sram_retain_o <= 1'b0;
      io_hold_o <= 1'b0;
      periph_retain_o <= 1'b0;
    end else begin
      unique case (mode_nxt)
        CPMC_WAIT, CPMC_VLP_WAIT: core_state_o <= CORE_SLEEP;
        CPMC_STOP, CPMC_VLP_STOP, CPMC_LL_STOP: core_state_o <= CORE_DEEP;
        default: core_state_o <= CORE_RUN;
      endcase
      // Interrupt controller only sensitive while the fast clock runs
      nested_irq_controller_en_o <= (mode_nxt != CPMC_STOP) && (mode_nxt != CPMC_VLP_STOP)
                                 && (mode_nxt != CPMC_LL_STOP);
      async_wake_irq_controller_en_o <= (mode_nxt == CPMC_STOP)
                                     || (mode_nxt == CPMC_VLP_STOP);
      low_leakage_wakeup_unit_en_o <= (mode_nxt == CPMC_LL_STOP);
      periph_clk_en_o <= (mode_nxt != CPMC_STOP) && (mode_nxt != CPMC_VLP_STOP)
                      && (mode_nxt != CPMC_LL_STOP);
      aon_clk_en_o <= aon_nxt;
      reg_lowpower_o <= vlp_family;
      flash_lp_o <= vlp_family;
      // Detect stays on in normal modes, off in all very-low-power ones
      low_voltage_detect_en_o <= !vlp_family;
      fast_core_clock_en_o <= (mode_nxt != CPMC_STOP) && (mode_nxt != CPMC_VLP_STOP)
                           && (mode_nxt != CPMC_LL_STOP);
      sram_retain_o <= (mode_nxt == CPMC_VLP_STOP) || (mode_nxt == CPMC_LL_STOP);
      io_hold_o <= (mode_nxt == CPMC_VLP_STOP) || (mode_nxt == CPMC_LL_STOP);
      periph_retain_o <= (mode_nxt == CPMC_LL_STOP);
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection in very-low-power modes
  // ----------------------------------------------------------------
  // Mode error is only flagged, software owns the clock generator setup
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      use_internal_ref_o <= 1'b0;
      use_crystal_o <= 1'b0;
      clk_mode_err_o <= 1'b0;
    end else begin
      use_internal_ref_o <= vlp_family && (clk_mode_i == CLKM_BYPASSED_LOWPOWER_INTERNAL_CLK);
      use_crystal_o <= vlp_family && (clk_mode_i == CLKM_BYPASSED_LOWPOWER_EXTERNAL_CLK)
                    && (ext_src_sel_i == SRC_CRYSTAL);
      clk_mode_err_o <= vlp_family && (clk_mode_i != CLKM_BYPASSED_LOWPOWER_INTERNAL_CLK)
                     && (clk_mode_i != CLKM_BYPASSED_LOWPOWER_EXTERNAL_CLK);
    end
  end

  // ----------------------------------------------------------------
  // Reduced flash and bus clock dividers
  // ----------------------------------------------------------------
  localparam int FW = $clog2(FLASH_LP_DIV);
  localparam int BW = $clog2(BUS_LP_DIV);
  localparam logic [FW-1:0] FLASH_HALF = FW'(FLASH_LP_DIV / 2 - 1);
  // Half period rounded up too: an odd divider cut down would push the bus over its ceiling
  localparam logic [BW-1:0] BUS_HALF = BW'((BUS_LP_DIV + 1) / 2 - 1);
  logic [FW-1:0] fdiv_r;
  logic [BW-1:0] bdiv_r;

  initial begin
    if (FLASH_LP_DIV < 2 || BUS_LP_DIV < 2) $error("cpmc_top: clock too slow for dividers");
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fdiv_r <= '0;
      flash_lp_clk_o <= 1'b0;
    end else if (!vlp_family) begin
      fdiv_r <= '0;
      flash_lp_clk_o <= 1'b0;
    end else if (fdiv_r == FLASH_HALF) begin
      fdiv_r <= '0;
      flash_lp_clk_o <= !flash_lp_clk_o;
    end else begin
      fdiv_r <= fdiv_r + 1'b1;
    end
  end

  // Divider rounded up so the bus never exceeds its ceiling
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bdiv_r <= '0;
      bus_lp_clk_o <= 1'b0;
    end else if (!vlp_family) begin
      bdiv_r <= '0;
      bus_lp_clk_o <= 1'b0;
    end else if (bdiv_r == BUS_HALF) begin
      bdiv_r <= '0;
      bus_lp_clk_o <= !bus_lp_clk_o;
    end else begin
      bdiv_r <= bdiv_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_o <= CPMC_RUN;
    end else begin
      mode_o <= mode_nxt;
    end
  end

endmodule : cpmc_top

// ### dv/cpmc_monitor.sv
// Checker: assertions on the power mode controller ports
`timescale 1ns/10ps
module cpmc_monitor
  import cpmc_pkg::*;
(
  // Clock, reset, requests
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic wfi_req_i,
  input wire logic deep_sel_i,
  input wire logic ll_stop_sel_i,
  input wire logic irq_pend_i,
  input wire logic low_leakage_wakeup_unit_wake_i,
  // Observed outputs
  input wire cpmc_pkg::cpmc_mode_t mode_o,
  input wire logic [1:0] core_state_o,
  input wire logic nested_irq_controller_en_o,
  input wire logic async_wake_irq_controller_en_o,
  input wire logic low_leakage_wakeup_unit_en_o,
  input wire logic periph_clk_en_o,
  input wire logic [PG_WIDTH-1:0] aon_clk_en_o,
  input wire logic reg_lowpower_o,
  input wire logic low_voltage_detect_en_o,
  input wire logic fast_core_clock_en_o,
  input wire logic sram_retain_o
);
  wire nv = nested_irq_controller_en_o;
  wire aw = async_wake_irq_controller_en_o;
  wire lw = low_leakage_wakeup_unit_en_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_reset_run: assert property ($rose(rstn_i) |-> mode_o == CPMC_RUN && !reg_lowpower_o)
    else $error("run mode not entered after reset");
  a_wfi_to_wait: assert property (mode_o == CPMC_RUN && wfi_req_i && !deep_sel_i
    |=> mode_o == CPMC_WAIT && core_state_o == CORE_SLEEP) else $error("wait not entered");
  a_wfi_to_stop: assert property (mode_o == CPMC_RUN && wfi_req_i && deep_sel_i
    && !ll_stop_sel_i |=> mode_o == CPMC_STOP) else $error("stop not entered");
  a_wait_outputs: assert property (mode_o == CPMC_WAIT |-> nv && periph_clk_en_o)
    else $error("wait controls wrong");
  a_stop_outputs: assert property (mode_o == CPMC_STOP |-> core_state_o == CORE_DEEP
    && !nv && aw && !periph_clk_en_o && low_voltage_detect_en_o) else $error("stop controls wrong");
  a_vlp_power: assert property (mode_o inside {CPMC_VLP_RUN, CPMC_VLP_WAIT, CPMC_VLP_STOP}
    |-> reg_lowpower_o && !low_voltage_detect_en_o) else $error("vlp power wrong");
  a_very_low_power_wait_fast_on: assert property (mode_o == CPMC_VLP_WAIT |-> fast_core_clock_en_o && nv)
    else $error("vlp wait controls wrong");
  a_very_low_power_stop_gating: assert property (mode_o == CPMC_VLP_STOP |-> !fast_core_clock_en_o && aw
    && aon_clk_en_o[4:0] == 5'h1f && sram_retain_o) else $error("vlp stop controls wrong");
  a_lls_outputs: assert property (mode_o == CPMC_LL_STOP |-> !nv && lw && !aw
    && aon_clk_en_o == 8'h9f && sram_retain_o) else $error("ll stop controls wrong");
  a_irq_wake: assert property (mode_o inside {CPMC_WAIT, CPMC_STOP} && $rose(irq_pend_i)
    |-> ##[2:6] mode_o == CPMC_RUN) else $error("interrupt wake late");
  a_low_leakage_wakeup_unit_wake: assert property (mode_o == CPMC_LL_STOP && $rose(low_leakage_wakeup_unit_wake_i)
    |-> ##[2:6] mode_o == CPMC_RUN) else $error("wake-up unit exit late");
endmodule : cpmc_monitor

// ### dv/cpmc_core_model.sv
// Partner: processor core sleep requests and wake sources
`timescale 1ns/10ps
module cpmc_core_model
  import cpmc_pkg::*;
(
  // Clock and core state seen
  input wire logic core_clk_i,
  input wire logic [1:0] core_state_i,
  // Requests and wakes
  output logic wfi_req_o,
  output logic deep_sel_o,
  output logic ll_stop_sel_o,
  output logic irq_pend_o,
  output logic low_leakage_wakeup_unit_wake_o,
  output logic [1:0] clk_mode_o
);
  import cpmc_pkg::*;
  int late;
  initial begin
    late = 0;
    wfi_req_o = 1'b0;
    deep_sel_o = 1'b0;
    ll_stop_sel_o = 1'b0;
    irq_pend_o = 1'b0;
    low_leakage_wakeup_unit_wake_o = 1'b0;
    clk_mode_o = CLKM_NORMAL;
  end
  // Only bypassed modes are ever asked for around very-low-power run
  task automatic set_clk(input logic [1:0] m);
    @(posedge core_clk_i);
    #1;
    clk_mode_o = m;
  endtask : set_clk
  task automatic sleep(input logic deep, input logic ll);
    @(posedge core_clk_i);
    #1;
    wfi_req_o = 1'b1;
    deep_sel_o = deep;
    ll_stop_sel_o = ll;
    @(posedge core_clk_i);
    #1;
    wfi_req_o = 1'b0;
    // Selects flip once unqualified, so late sampling shows
    deep_sel_o = ~deep;
    ll_stop_sel_o = ~ll;
  endtask : sleep
  // Wake held until the core runs; slow sets the delay before it
  task automatic wake(input logic via_low_leakage_wakeup_unit, input int slow);
    int n;
    repeat (slow) @(posedge core_clk_i);
    #1;
    if (via_low_leakage_wakeup_unit) low_leakage_wakeup_unit_wake_o = 1'b1;
    else irq_pend_o = 1'b1;
    n = 0;
    while (core_state_i !== CORE_RUN && n < 20) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n == 20) late++;
    irq_pend_o = 1'b0;
    low_leakage_wakeup_unit_wake_o = 1'b0;
  endtask : wake
endmodule : cpmc_core_model

// ### dv/tb_top.sv
// Testbench: walk through every power mode and back
`timescale 1ns/10ps
module tb_top;
  import cpmc_pkg::*;
  logic core_clk_i, rstn_i, wfi_req_i, deep_sel_i, vlp_req_i, ll_stop_sel_i;
  logic irq_pend_i, low_leakage_wakeup_unit_wake_i, ext_src_sel_i, tpm_src_on_i, uart_src_on_i;
  logic [1:0] clk_mode_i, core_state_o;
  cpmc_mode_t mode_o;
  logic nested_irq_controller_en_o, async_wake_irq_controller_en_o;
  logic low_leakage_wakeup_unit_en_o, periph_clk_en_o, reg_lowpower_o, flash_lp_o;
  logic flash_lp_clk_o, bus_lp_clk_o, low_voltage_detect_en_o, fast_core_clock_en_o;
  logic sram_retain_o, io_hold_o, periph_retain_o, use_internal_ref_o, use_crystal_o;
  logic clk_mode_err_o;
  logic [PG_WIDTH-1:0] aon_clk_en_o;
  int failures, num_checks, n;
  cpmc_top uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .wfi_req_i(wfi_req_i),
    .deep_sel_i(deep_sel_i), .vlp_req_i(vlp_req_i), .ll_stop_sel_i(ll_stop_sel_i),
    .irq_pend_i(irq_pend_i), .low_leakage_wakeup_unit_wake_i(low_leakage_wakeup_unit_wake_i), .clk_mode_i(clk_mode_i),
    .ext_src_sel_i(ext_src_sel_i), .tpm_src_on_i(tpm_src_on_i), .uart_src_on_i(uart_src_on_i),
    .mode_o(mode_o), .core_state_o(core_state_o),
    .nested_irq_controller_en_o(nested_irq_controller_en_o),
    .async_wake_irq_controller_en_o(async_wake_irq_controller_en_o),
    .low_leakage_wakeup_unit_en_o(low_leakage_wakeup_unit_en_o),
    .periph_clk_en_o(periph_clk_en_o), .aon_clk_en_o(aon_clk_en_o),
    .reg_lowpower_o(reg_lowpower_o), .flash_lp_o(flash_lp_o), .flash_lp_clk_o(flash_lp_clk_o),
    .bus_lp_clk_o(bus_lp_clk_o), .low_voltage_detect_en_o(low_voltage_detect_en_o),
    .fast_core_clock_en_o(fast_core_clock_en_o), .sram_retain_o(sram_retain_o),
    .io_hold_o(io_hold_o), .periph_retain_o(periph_retain_o),
    .use_internal_ref_o(use_internal_ref_o), .use_crystal_o(use_crystal_o),
    .clk_mode_err_o(clk_mode_err_o));
  cpmc_core_model core (.core_clk_i(core_clk_i), .core_state_i(core_state_o),
    .wfi_req_o(wfi_req_i), .deep_sel_o(deep_sel_i), .ll_stop_sel_o(ll_stop_sel_i),
    .irq_pend_o(irq_pend_i), .low_leakage_wakeup_unit_wake_o(low_leakage_wakeup_unit_wake_i), .clk_mode_o(clk_mode_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task automatic wait_mode(input cpmc_mode_t m);
    int k;
    k = 0;
    while (mode_o !== m && k < 40) begin
      cyc(1);
      k++;
    end
    if (k == 40) begin
      failures++;
      conclude();
    end
    chk(mode_o, m);
  endtask : wait_mode
  // Cycles between two toggles of a divided clock
  task automatic half(input bit bus, output int cnt);
    logic v;
    repeat (2) begin
      v = bus ? bus_lp_clk_o : flash_lp_clk_o;
      cnt = 0;
      while ((bus ? bus_lp_clk_o : flash_lp_clk_o) === v && cnt < 400) begin
        cyc(1);
        cnt++;
      end
      if (cnt == 400) begin
        failures++;
        conclude();
      end
    end
  endtask : half
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_normal;
    chk(mode_o, CPMC_RUN);
    chk({core_state_o, reg_lowpower_o, low_voltage_detect_en_o, nested_irq_controller_en_o,
      periph_clk_en_o, fast_core_clock_en_o}, 8'h0f);
    core.sleep(1'b0, 1'b0);
    chk(mode_o, CPMC_WAIT);
    chk({core_state_o, nested_irq_controller_en_o, periph_clk_en_o}, 8'h07);
    core.wake(1'b0, 3);
    wait_mode(CPMC_RUN);
    // Let the synchronised wake drain so it cannot end the next sleep at once
    cyc(6);
    core.sleep(1'b1, 1'b0);
    chk(mode_o, CPMC_STOP);
    chk({core_state_o, nested_irq_controller_en_o, async_wake_irq_controller_en_o,
      periph_clk_en_o, low_voltage_detect_en_o}, 8'h25);
    core.wake(1'b0, 0);
    wait_mode(CPMC_RUN);
  endtask : t_normal
  task automatic t_vlp;
    core.set_clk(CLKM_BYPASSED_LOWPOWER_INTERNAL_CLK);
    vlp_req_i = 1'b1;
    wait_mode(CPMC_VLP_RUN);
    cyc(1);
    chk({reg_lowpower_o, flash_lp_o, low_voltage_detect_en_o, use_internal_ref_o,
      clk_mode_err_o}, 8'h1a);
    half(1'b0, n);
    chk(n, FLASH_LP_DIV / 2);
    half(1'b1, n);
    chk(n * 2 * BUS_LP_MAX_KHZ > CLK_RATE_KHZ, 8'h01);
    core.set_clk(CLKM_BYPASSED_LOWPOWER_EXTERNAL_CLK);
    cyc(2);
    chk({use_crystal_o, use_internal_ref_o, clk_mode_err_o}, 8'h04);
    ext_src_sel_i = 1'b0;
    cyc(1);
    chk({use_crystal_o, clk_mode_err_o}, 8'h00);
    core.sleep(1'b0, 1'b0);
    chk(mode_o, CPMC_VLP_WAIT);
    chk({core_state_o, fast_core_clock_en_o, nested_irq_controller_en_o,
      reg_lowpower_o}, 8'h0f);
    core.wake(1'b0, 2);
    wait_mode(CPMC_VLP_RUN);
    cyc(6);
    core.sleep(1'b1, 1'b0);
    chk(mode_o, CPMC_VLP_STOP);
    chk(aon_clk_en_o, 8'h3f);
    tpm_src_on_i = 1'b0;
    uart_src_on_i = 1'b1;
    cyc(1);
    chk(aon_clk_en_o, 8'h5f);
    chk({fast_core_clock_en_o, nested_irq_controller_en_o, async_wake_irq_controller_en_o,
      sram_retain_o, io_hold_o, low_voltage_detect_en_o}, 8'h0e);
    core.wake(1'b0, 5);
    wait_mode(CPMC_VLP_RUN);
    vlp_req_i = 1'b0;
    wait_mode(CPMC_RUN);
  endtask : t_vlp
  task automatic t_lls;
    core.sleep(1'b1, 1'b1);
    chk(mode_o, CPMC_LL_STOP);
    chk({nested_irq_controller_en_o, low_leakage_wakeup_unit_en_o, sram_retain_o, io_hold_o,
      periph_retain_o}, 8'h0f);
    chk(aon_clk_en_o, 8'h9f);
    core.wake(1'b1, 4);
    wait_mode(CPMC_RUN);
    chk(core.late, 8'h00);
  endtask : t_lls
  task automatic t_reset;
    vlp_req_i = 1'b1;
    wait_mode(CPMC_VLP_RUN);
    rstn_i = 1'b0;
    cyc(2);
    chk(mode_o, CPMC_RUN);
    chk({reg_lowpower_o, low_voltage_detect_en_o}, 8'h01);
    vlp_req_i = 1'b0;
    rstn_i = 1'b1;
    cyc(2);
    chk(mode_o, CPMC_RUN);
  endtask : t_reset
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    failures = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    vlp_req_i = 1'b0;
    ext_src_sel_i = 1'b1;
    tpm_src_on_i = 1'b1;
    uart_src_on_i = 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    cyc(1);
    t_normal();
    t_vlp();
    t_lls();
    t_reset();
    conclude();
  end
endmodule : tb_top
bind cpmc_top cpmc_monitor mon (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .wfi_req_i(wfi_req_i), .deep_sel_i(deep_sel_i), .ll_stop_sel_i(ll_stop_sel_i),
  .irq_pend_i(irq_pend_i), .low_leakage_wakeup_unit_wake_i(low_leakage_wakeup_unit_wake_i), .mode_o(mode_o),
  .core_state_o(core_state_o), .nested_irq_controller_en_o(nested_irq_controller_en_o),
  .async_wake_irq_controller_en_o(async_wake_irq_controller_en_o),
  .low_leakage_wakeup_unit_en_o(low_leakage_wakeup_unit_en_o),
  .periph_clk_en_o(periph_clk_en_o), .aon_clk_en_o(aon_clk_en_o),
  .reg_lowpower_o(reg_lowpower_o), .low_voltage_detect_en_o(low_voltage_detect_en_o),
  .fast_core_clock_en_o(fast_core_clock_en_o), .sram_retain_o(sram_retain_o));
